// ===== rtl/aogtr_fuse_loader.sv
/*
 aogtr_fuse_loader: walks all trim slots and fetches each default word from fuse storage.
 assumes: fuse storage answers each read with fuse_rvalid on sys_clk, any latency of one cycle or more after fuse_rd_en.
*/
`timescale 1ns/1ps
`default_nettype none
module aogtr_fuse_loader (
	input wire logic sys_clk,
	input wire logic srst,
	aogtr_load_if.loader ld,
	output logic fuse_rd_en,
	output logic [2:0] fuse_addr,
	input wire logic [15:0] fuse_rdata,
	input wire logic fuse_rvalid
);
	aogtr_pkg::aogtr_ld_state_t state_r;
	logic [2:0] slot_r;
	logic wr_valid_r;
	logic [2:0] wr_slot_r;
	logic [15:0] wr_data_r;
	wire got = (state_r == aogtr_pkg::LD_WAIT) && fuse_rvalid;
	wire last = (slot_r == aogtr_pkg::SLOT_LAST);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_r <= aogtr_pkg::LD_IDLE;
			slot_r <= 3'h0;
		end
		else
		begin
			unique case (state_r)
				aogtr_pkg::LD_IDLE:
				begin
					if (ld.start)
					begin
						slot_r <= 3'h0;
						state_r <= aogtr_pkg::LD_REQ;
					end
				end
				aogtr_pkg::LD_REQ:
					state_r <= aogtr_pkg::LD_WAIT;
				aogtr_pkg::LD_WAIT:
				begin
					if (fuse_rvalid)
					begin
						slot_r <= last ? 3'h0 : slot_r + 3'h1;
						state_r <= last ? aogtr_pkg::LD_IDLE : aogtr_pkg::LD_REQ;
					end
				end
				default:
					state_r <= aogtr_pkg::LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_valid_r <= 1'b0;
			wr_slot_r <= 3'h0;
			wr_data_r <= 16'h0000;
		end
		else
		begin
			wr_valid_r <= got;
			wr_slot_r <= slot_r;
			wr_data_r <= fuse_rdata;
		end
	end

	assign fuse_rd_en = (state_r == aogtr_pkg::LD_REQ);
	assign fuse_addr = slot_r;
	assign ld.wr_valid = wr_valid_r;
	assign ld.wr_slot = wr_slot_r;
	assign ld.wr_data = wr_data_r;
	// busy covers the last write so no bus write can slip in before it lands
	assign ld.busy = (state_r != aogtr_pkg::LD_IDLE) || wr_valid_r;
endmodule
`default_nettype wire

// ===== rtl/aogtr_load_if.sv
/*
 aogtr_load_if: carries fuse default words from the loader to the register bank.
 assumes: both ends on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface aogtr_load_if;
	logic start;
	logic busy;
	logic wr_valid;
	logic [2:0] wr_slot;
	logic [15:0] wr_data;
	modport loader (input start, output busy, output wr_valid, output wr_slot, output wr_data);
	modport regs (output start, input busy, input wr_valid, input wr_slot, input wr_data);
endinterface
`default_nettype wire

// ===== rtl/aogtr_pkg.sv
/*
 aogtr_pkg: constants and types for the offset and gain trim register bank.
 assumes: word-addressed register indices, byte address is four times the index.
*/
package aogtr_pkg;
	localparam int NSLOT = 7;
	localparam int IDX_W = 10;
	localparam int SLOT_W = 3;
	localparam int REG_W = 16;
	localparam int OFS_W = 12;
	localparam int GAIN_W = 5;
	localparam int OFS_REG_W = 16;
	localparam int GAIN_REG_W = 8;
	localparam logic [9:0] IDX_A_OFS90 = 10'h34a;
	localparam logic [9:0] IDX_B_OFS_IN1 = 10'h34c;
	localparam logic [9:0] IDX_B_OFS_IN2 = 10'h34e;
	localparam logic [9:0] IDX_A_GAIN0 = 10'h350;
	localparam logic [9:0] IDX_A_GAIN1 = 10'h351;
	localparam logic [9:0] IDX_B_GAIN0 = 10'h352;
	localparam logic [9:0] IDX_B_GAIN1 = 10'h353;
	localparam logic [9:0] IDX_CTRL = 10'h3f0;
	localparam logic [2:0] SLOT_A_OFS90 = 3'h0;
	localparam logic [2:0] SLOT_B_OFS_IN1 = 3'h1;
	localparam logic [2:0] SLOT_B_OFS_IN2 = 3'h2;
	localparam logic [2:0] SLOT_A_GAIN0 = 3'h3;
	localparam logic [2:0] SLOT_A_GAIN1 = 3'h4;
	localparam logic [2:0] SLOT_B_GAIN0 = 3'h5;
	localparam logic [2:0] SLOT_B_GAIN1 = 3'h6;
	localparam logic [2:0] SLOT_LAST = 3'h6;
	localparam logic [15:0] RST_OFS = 16'h0000;
	localparam logic [15:0] RST_GAIN = 16'h0000;
	localparam logic [15:0] MASK_OFS = 16'hffff;
	localparam logic [15:0] MASK_GAIN = 16'h00ff;
	localparam int CTRL_RELOAD_BIT = 0;
	localparam int CTRL_BUSY_BIT = 1;
	localparam int CTRL_DONE_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		LD_IDLE = 3'h1,
		LD_REQ = 3'h2,
		LD_WAIT = 3'h4
	} aogtr_ld_state_t;
endpackage

// ===== rtl/aogtr_regs.sv
/*
 aogtr_regs: AXI4-Lite bank of converter offset and dual-mode gain trims,
 with fuse default loading and registered trim outputs to the converter cores.
 assumes: converter mode inputs are on sys_clk; fuse storage per aogtr_fuse_loader.
*/
`timescale 1ns/1ps
`default_nettype none
module aogtr_regs (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic fuse_rd_en,
	output logic [2:0] fuse_addr,
	input wire logic [15:0] fuse_rdata,
	input wire logic fuse_rvalid,
	input wire logic fg_cal_en,
	input wire logic single_channel_mode,
	input wire logic first_core_input_sel,
	input wire logic first_core_phase90,
	input wire logic second_core_input_sel,
	output logic [11:0] first_core_second_input_offset_phase90,
	output logic first_core_offset_phase90_apply,
	output logic [11:0] second_core_offset,
	output logic second_core_offset_apply,
	output logic [4:0] first_core_bank0_gain_trim,
	output logic [4:0] first_core_bank1_gain_trim,
	output logic [4:0] second_core_bank0_gain_trim,
	output logic [4:0] second_core_bank1_gain_trim,
	output logic dual_gain_apply
);
	logic [15:0] trim_r [aogtr_pkg::NSLOT];
	logic aw_have_r;
	logic [9:0] aw_idx_r;
	logic w_have_r;
	logic [15:0] w_data_r;
	logic [1:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic load_pend_r;
	logic done_r;
	logic [11:0] a_ofs90_r;
	logic a_ofs90_apply_r;
	logic [11:0] b_ofs_r;
	logic b_ofs_apply_r;
	logic [4:0] gain_r [4];
	logic gain_apply_r;

	aogtr_load_if ld ();

	aogtr_fuse_loader u_loader (
		.sys_clk(sys_clk),
		.srst(srst),
		.ld(ld.loader),
		.fuse_rd_en(fuse_rd_en),
		.fuse_addr(fuse_addr),
		.fuse_rdata(fuse_rdata),
		.fuse_rvalid(fuse_rvalid)
	);

	// index to slot; bit 3 set means the index is not a trim register
	function automatic logic [3:0] slot_of(input logic [9:0] idx);
		unique case (idx)
			aogtr_pkg::IDX_A_OFS90: slot_of = {1'b0, aogtr_pkg::SLOT_A_OFS90};
			aogtr_pkg::IDX_B_OFS_IN1: slot_of = {1'b0, aogtr_pkg::SLOT_B_OFS_IN1};
			aogtr_pkg::IDX_B_OFS_IN2: slot_of = {1'b0, aogtr_pkg::SLOT_B_OFS_IN2};
			aogtr_pkg::IDX_A_GAIN0: slot_of = {1'b0, aogtr_pkg::SLOT_A_GAIN0};
			aogtr_pkg::IDX_A_GAIN1: slot_of = {1'b0, aogtr_pkg::SLOT_A_GAIN1};
			aogtr_pkg::IDX_B_GAIN0: slot_of = {1'b0, aogtr_pkg::SLOT_B_GAIN0};
			aogtr_pkg::IDX_B_GAIN1: slot_of = {1'b0, aogtr_pkg::SLOT_B_GAIN1};
			default: slot_of = 4'h8;
		endcase
	endfunction

	// offset slots keep 16 bits, gain slots 8; reserved bits stay storable
	function automatic logic [15:0] mask_of(input logic [2:0] slot);
		mask_of = (slot <= aogtr_pkg::SLOT_B_OFS_IN2) ? aogtr_pkg::MASK_OFS
			: aogtr_pkg::MASK_GAIN;
	endfunction

	// write path
	wire wr_blocked = load_pend_r || ld.busy;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
	wire [3:0] wr_slot_hit = slot_of(aw_idx_r);
	wire wr_is_trim = !wr_slot_hit[3];
	wire wr_is_ctrl = (aw_idx_r == aogtr_pkg::IDX_CTRL);
	wire [15:0] wr_lane = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire [15:0] wr_mask = wr_lane & mask_of(wr_slot_hit[2:0]);
	wire reload_req = wr_fire && wr_is_ctrl && w_strb_r[0]
		&& w_data_r[aogtr_pkg::CTRL_RELOAD_BIT];

	assign s_axi_awready = !aw_have_r && !bvalid_r && !wr_blocked;
	assign s_axi_wready = !w_have_r && !bvalid_r && !wr_blocked;
	assign ld.start = load_pend_r;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			aw_have_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_have_r <= 1'b0;
			w_data_r <= 16'h0000;
			w_strb_r <= 2'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_have_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[11:2];
			end
			else if (wr_fire)
				aw_have_r <= 1'b0;
			if (w_take)
			begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata[15:0];
				w_strb_r <= s_axi_wstrb[1:0];
			end
			else if (wr_fire)
				w_have_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= aogtr_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_is_trim || wr_is_ctrl) ? aogtr_pkg::RESP_OKAY
				: aogtr_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// fuse load runs once after reset and again on each reload request
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			load_pend_r <= 1'b1;
			done_r <= 1'b0;
		end
		else
		begin
			if (reload_req)
				load_pend_r <= 1'b1;
			else if (ld.busy)
				load_pend_r <= 1'b0;
			if (ld.wr_valid && ld.wr_slot == aogtr_pkg::SLOT_LAST)
				done_r <= 1'b1;
			else if (load_pend_r)
				done_r <= 1'b0;
		end
	end

	// trim storage; bus writes cannot meet loader writes since bus is held off
	genvar gs;
	generate
		for (gs = 0; gs < aogtr_pkg::NSLOT; gs++)
		begin : g_slot
			wire fuse_hit = ld.wr_valid && ld.wr_slot == 3'(gs);
			wire bus_hit = wr_fire && wr_is_trim && wr_slot_hit[2:0] == 3'(gs);
			wire [15:0] msk = mask_of(3'(gs));
			always_ff @(posedge sys_clk)
			begin
				if (srst)
					trim_r[gs] <= (gs <= 2) ? aogtr_pkg::RST_OFS : aogtr_pkg::RST_GAIN;
				else if (fuse_hit)
					trim_r[gs] <= ld.wr_data & msk;
				else if (bus_hit)
					trim_r[gs] <= (trim_r[gs] & ~wr_mask) | (w_data_r & wr_mask);
			end
		end
	endgenerate

	// read path
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [9:0] rd_idx = s_axi_araddr[11:2];
	wire [3:0] rd_slot_hit = slot_of(rd_idx);
	wire rd_is_ctrl = (rd_idx == aogtr_pkg::IDX_CTRL);
	wire [31:0] rd_trim = {16'h0000, trim_r[rd_slot_hit[2:0]]};
	wire [31:0] rd_ctrl = {29'h0, done_r, ld.busy || load_pend_r, 1'b0};

	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= aogtr_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (ar_take)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= (!rd_slot_hit[3] || rd_is_ctrl) ? aogtr_pkg::RESP_OKAY
				: aogtr_pkg::RESP_SLVERR;
			rdata_r <= !rd_slot_hit[3] ? rd_trim : (rd_is_ctrl ? rd_ctrl : 32'h0000_0000);
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// trim selection toward the converter cores
	wire a_ofs90_cond = fg_cal_en && single_channel_mode && first_core_input_sel
		&& first_core_phase90;
	// channel mode deliberately not a term here
	wire [11:0] b_ofs_sel = second_core_input_sel
		? trim_r[aogtr_pkg::SLOT_B_OFS_IN2][11:0]
		: trim_r[aogtr_pkg::SLOT_B_OFS_IN1][11:0];
	wire gain_cond = fg_cal_en && !single_channel_mode;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			a_ofs90_r <= 12'h000;
			a_ofs90_apply_r <= 1'b0;
			b_ofs_r <= 12'h000;
			b_ofs_apply_r <= 1'b0;
			gain_apply_r <= 1'b0;
		end
		else
		begin
			a_ofs90_r <= trim_r[aogtr_pkg::SLOT_A_OFS90][11:0];
			a_ofs90_apply_r <= a_ofs90_cond;
			b_ofs_r <= b_ofs_sel;
			b_ofs_apply_r <= fg_cal_en;
			gain_apply_r <= gain_cond;
		end
	end

	// gain trims: only the low five bits reach the cores
	genvar gg;
	generate
		for (gg = 0; gg < 4; gg++)
		begin : g_gain
			always_ff @(posedge sys_clk)
			begin
				if (srst)
					gain_r[gg] <= 5'h00;
				else
					gain_r[gg] <= trim_r[3 + gg][4:0];
			end
		end
	endgenerate

	assign first_core_second_input_offset_phase90 = a_ofs90_r;
	assign first_core_offset_phase90_apply = a_ofs90_apply_r;
	assign second_core_offset = b_ofs_r;
	assign second_core_offset_apply = b_ofs_apply_r;
	assign first_core_bank0_gain_trim = gain_r[0];
	assign first_core_bank1_gain_trim = gain_r[1];
	assign second_core_bank0_gain_trim = gain_r[2];
	assign second_core_bank1_gain_trim = gain_r[3];
	assign dual_gain_apply = gain_apply_r;

	// awprot and arprot carry no meaning for this bank
	wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_awaddr[31:12],
		s_axi_awaddr[1:0], s_axi_araddr[31:12], s_axi_araddr[1:0],
		s_axi_wdata[31:16], s_axi_wstrb[3:2]};
endmodule
`default_nettype wire

// ===== test/adc_offset_gain_trim_regs_test.sv
/*
 adc_offset_gain_trim_regs_test: self-checking bench for aogtr_regs.
 assumes: bench acts as bus master and fuse storage, fuse answers next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_offset_gain_trim_regs_test;
logic sys_clk, srst, fuse_rd_en, fuse_rvalid;
logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
logic [2:0] s_axi_awprot, s_axi_arprot, fuse_addr;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [15:0] fuse_rdata;
logic fg_cal_en, single_channel_mode, first_core_input_sel, first_core_phase90;
logic second_core_input_sel;
logic [11:0] first_core_second_input_offset_phase90, second_core_offset;
logic first_core_offset_phase90_apply, second_core_offset_apply, dual_gain_apply;
logic [4:0] first_core_bank0_gain_trim, first_core_bank1_gain_trim;
logic [4:0] second_core_bank0_gain_trim, second_core_bank1_gain_trim;
int num_errors, comparisons;
logic [9:0] ix[7] = '{10'h34a, 10'h34c, 10'h34e, 10'h350, 10'h351, 10'h352, 10'h353};
logic [31:0] wd[7] = '{32'hdead_f123, 32'ha5c3, 32'h1234_7e81, 32'h1e7, 32'hf9, 32'haa, 32'h31f};
logic [31:0] rr[7] = '{32'hf123, 32'ha5c3, 32'h7e81, 32'he7, 32'hf9, 32'haa, 32'h1f};
logic [4:0] mi[6] = '{5'b11110, 5'b11011, 5'b10111, 5'b11100, 5'b01111, 5'b10000};
logic [2:0] me[6] = '{3'b110, 3'b010, 3'b011, 3'b010, 3'b000, 3'b011};
aogtr_regs aogtr_regs_inst (.*);
initial
begin
	sys_clk = 1'b0;
	forever #2.5 sys_clk = ~sys_clk;
end
// arbitrary fuse contents, distinct per slot
function automatic logic [15:0] fw(input int i);
	return 16'h9a50 + 16'(i);
endfunction
// released data line shows the inverse, not a stale word
always @(posedge sys_clk)
begin
	fuse_rvalid <= fuse_rd_en;
	fuse_rdata <= fuse_rd_en ? fw(int'(fuse_addr)) : ~fuse_rdata;
end
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
	comparisons++;
	if (g !== e)
	begin
		num_errors++;
		$display("[ERR] %s expected %h seen %h", n, e, g);
	end
endtask
task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
	int n;
	r = 2'bxx;
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_wstrb <= s;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	for (n = 0; n < 200; n++)
	begin
		@(posedge sys_clk);
		if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		// bready stays high for the whole run, so the answer is taken at this edge
		if (s_axi_bready && s_axi_bvalid)
		begin
			r = s_axi_bresp;
			break;
		end
	end
	chk("write finished", 1, 32'(n < 200));
endtask
task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
	int n;
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	for (n = 0; n < 200; n++)
	begin
		@(posedge sys_clk);
		if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		if (s_axi_rready && s_axi_rvalid)
		begin
			d = s_axi_rdata;
			r = s_axi_rresp;
			break;
		end
	end
	chk("read finished", 1, 32'(n < 200));
endtask
task wait_load;
	logic [31:0] d;
	logic [1:0] r;
	for (int k = 0; k < 100; k++)
	begin
		rd(32'hfc0, d, r);
		if (d[2] === 1'b1 && d[1] === 1'b0) break;
	end
	chk("load done", 32'h4, d & 32'h6);
endtask
task stop_test;
	$display("errors %0d comparisons %0d", num_errors, comparisons);
	if (num_errors == 0 && comparisons > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
initial
begin
	repeat (20000) @(posedge sys_clk);
	num_errors++;
	stop_test;
end
initial
begin
	logic [31:0] d;
	logic [1:0] r;
	srst = 1'b1;
	{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00101;
	{fg_cal_en, single_channel_mode, first_core_input_sel, first_core_phase90} = '0;
	second_core_input_sel = 1'b0;
	repeat (6) @(posedge sys_clk);
	chk("phase90 offset in reset", 0, 32'(first_core_second_input_offset_phase90));
	srst <= 1'b0;
	@(posedge sys_clk);
	wait_load;
	for (int k = 0; k < 7; k++)
	begin
		rd({20'h0, ix[k], 2'b00}, d, r);
		chk("fuse default", k < 3 ? 32'(fw(k)) : 32'(fw(k) & 16'hff), d);
	end
	for (int k = 0; k < 7; k++)
	begin
		wr({20'h0, ix[k], 2'b00}, wd[k], 4'hf, r);
		chk("write resp", 0, 32'(r));
		rd({20'h0, ix[k], 2'b00}, d, r);
		chk("read back", rr[k], d);
	end
	repeat (2) @(posedge sys_clk);
	chk("phase90 offset", 32'h123, 32'(first_core_second_input_offset_phase90));
	chk("a bank0 gain", 32'h07, 32'(first_core_bank0_gain_trim));
	chk("a bank1 gain", 32'h19, 32'(first_core_bank1_gain_trim));
	chk("b bank0 gain", 32'h0a, 32'(second_core_bank0_gain_trim));
	chk("b bank1 gain", 32'h1f, 32'(second_core_bank1_gain_trim));
	for (int k = 0; k < 6; k++)
	begin
		{fg_cal_en, single_channel_mode, first_core_input_sel, first_core_phase90,
			second_core_input_sel} <= mi[k];
		repeat (3) @(posedge sys_clk);
		chk("apply flags", 32'(me[k]), 32'({first_core_offset_phase90_apply,
			second_core_offset_apply, dual_gain_apply}));
		chk("b offset", mi[k][0] ? 32'he81 : 32'h5c3, 32'(second_core_offset));
	end
	wr(32'h4, 32'hffff, 4'hf, r);
	chk("unmapped bresp", 32'h2, 32'(r));
	rd(32'h4, d, r);
	chk("unmapped rresp", 32'h2, 32'(r));
	chk("unmapped rdata", 0, d);
	// reload must put fuse words back over software values
	wr(32'hfc0, 32'h1, 4'h1, r);
	wait_load;
	rd(32'hd28, d, r);
	chk("reloaded slot0", 32'(fw(0)), d);
	// second reset in mid-run: trims clear, then fuse defaults come back
	srst <= 1'b1;
	repeat (2) @(posedge sys_clk);
	chk("phase90 offset in mid reset", 0, 32'(first_core_second_input_offset_phase90));
	chk("gain in mid reset", 0, 32'(first_core_bank0_gain_trim));
	srst <= 1'b0;
	@(posedge sys_clk);
	wait_load;
	rd(32'hd40, d, r);
	chk("slot3 after mid reset", 32'(fw(3) & 16'hff), d);
	stop_test;
end
endmodule
bind aogtr_regs aogtr_regs_properties aogtr_regs_properties_inst (.*);
`default_nettype wire

// ===== test/aogtr_regs_properties.sv
/*
 aogtr_regs_properties: port assertions for the trim register bank.
 assumes: bound to aogtr_regs, one clock, srst synchronous active high.
*/
`timescale 1ns/1ps
`default_nettype none
module aogtr_regs_properties (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic fuse_rd_en,
	input wire logic [2:0] fuse_addr,
	input wire logic fg_cal_en,
	input wire logic single_channel_mode,
	input wire logic first_core_input_sel,
	input wire logic first_core_phase90,
	input wire logic first_core_offset_phase90_apply,
	input wire logic second_core_offset_apply,
	input wire logic dual_gain_apply
);
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
sequence s_both_taken;
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_read_taken;
	s_axi_arvalid && s_axi_arready;
endsequence
a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
	else $error("write response late");
a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
	else $error("read response late");
a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
	else $error("write response dropped");
a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data dropped");
a_fuse_pulse: assert property (fuse_rd_en |=> !fuse_rd_en && $stable(fuse_addr))
	else $error("fuse request not a pulse");
// $past needs one clean cycle after reset, hence the guard
a_phase_apply: assert property (!$past(srst) |-> first_core_offset_phase90_apply ==
	$past(fg_cal_en && single_channel_mode && first_core_input_sel && first_core_phase90))
	else $error("phase90 apply wrong");
a_second_apply: assert property (!$past(srst) |-> second_core_offset_apply == $past(fg_cal_en))
	else $error("second core apply wrong");
a_dual_apply: assert property (!$past(srst) |->
	dual_gain_apply == $past(fg_cal_en && !single_channel_mode))
	else $error("dual gain apply wrong");
a_reset_quiet: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid)
	else $error("response during reset");
endmodule
`default_nettype wire
